// File: hw/ubc_pkg.sv
// shared constants and types for the burst control link
package ubc_pkg;
  localparam int unsigned    CLK_MHZ           = 100;
  localparam logic [1:0]     MODE_CMD          = 2'h0;
  localparam logic [1:0]     MODE_PIN_A        = 2'h1;
  localparam logic [1:0]     MODE_TWO_PIN      = 2'h2;
  localparam logic [1:0]     MODE_CLK_ONLY     = 2'h3;
  localparam int unsigned    PULSE_W           = 8;
  localparam int unsigned    TIMEOUT_W         = 3;
  localparam int unsigned    LEVEL_W           = 4;
  // blank-out unit time in microseconds per timeout step
  localparam int unsigned    BLANK_UNIT_US     = 1;
  localparam int unsigned    BLANK_UNIT_CYC    = BLANK_UNIT_US * CLK_MHZ;
  localparam int unsigned    BLANK_W           = 12;
  localparam logic [BLANK_W-1:0] BLANK_RST     = 12'h000;
  localparam logic [PULSE_W-1:0] PULSE_RST     = 8'h00;
  localparam logic           HIZ_RST           = 1'b1;
  // two-pin overlap: half an internal clock period, in reference cycles
  localparam int unsigned    OVERLAP_CYC       = 2;
  localparam logic [1:0]     OVERLAP_RST       = 2'h0;
  typedef enum logic [1:0] {UBC_IDLE, UBC_ARMED, UBC_BURST, UBC_BLANK} ubc_state_e;
endpackage

// File: hw/ubc_link_if.sv
// pin-level link between the controller and the burst device
`timescale 1ns/1ps
interface ubc_link_if;
  logic                  control_pin_a;
  logic                  clock_pin_b;
  logic                  cmd_trigger;
  logic                  supply_recharge_trigger;
  logic                  supply_ready_flag;
  modport dev  (input control_pin_a, clock_pin_b, cmd_trigger, supply_recharge_trigger,
                output supply_ready_flag);
  modport host (output control_pin_a, clock_pin_b, cmd_trigger, supply_recharge_trigger,
                input supply_ready_flag);
endinterface

// File: hw/ubc_device.sv
// burst control and drive-supply gating of the transducer device
`timescale 1ns/1ps
// Summary of operation
// - stop charging once supply reaches selected level; code stops on supply_at_level_in and ignores the level select
// - regulation off at reset until hiz cleared
// - listen-disable stops charging after burst end
// - recharge trigger turns charging back on
// - status shows supply ready for burst
// - trigger set at start of burst keeps charging after burst
// - hiz flag overrides listen and trigger control
// - mode field selects; enable then falling edge
// - mode 0: command enables, pin b starts
// - modes 0,1,3 count pin b fall periods
// - mode 0 ends on count or command clear
// - mode 0 rearm needs command toggle
// - mode 1: pin a low enables, b starts
// - mode 1 ends on count or a high
// - mode 1 rearm needs pin a toggle
// - in burst outputs follow pin levels
// - mode 2: any fall enables, a starts
// - mode 2 overlap ends and disarms burst
// - mode 2 ignores pulse count
// - mode 3: pin b fall enables, starts, counts
// - mode 3 blank-out after end of burst
// - host holds pin b high before enable
// - zero count bursts continuously, not mode 3
module ubc_device (
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic                          clk_en_in,
  ubc_link_if.dev                            link,
  input  wire logic [1:0]                    io_mode_in,
  input  wire logic [ubc_pkg::PULSE_W-1:0]   burst_pulse_in,
  input  wire logic [ubc_pkg::TIMEOUT_W-1:0] drive_fault_timeout_in,
  input  wire logic [ubc_pkg::LEVEL_W-1:0]   drive_supply_level_sel_in,
  input  wire logic                          listen_charge_disable_in,
  input  wire logic                          hiz_clear_in,
  input  wire logic                          supply_at_level_in,
  output logic                               drive_out_a_out,
  output logic                               drive_out_b_out,
  output logic                               charge_enable_out,
  output logic                               drive_supply_hiz_flag_out,
  output logic                               burst_active_out
);
  import ubc_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] sa_q, sb_q, sr_q;
  logic       a_q, b_q, a_prev_q, b_prev_q, cmd_prev_q;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sa_q     <= 2'h3;
      sb_q     <= 2'h3;
      sr_q     <= 2'h0;
      a_q      <= 1'b1;
      b_q      <= 1'b1;
      a_prev_q <= 1'b1;
      b_prev_q <= 1'b1;
      cmd_prev_q <= 1'b0;
    end else if (clk_en_in) begin
      sa_q     <= {sa_q[0], link.control_pin_a};
      sb_q     <= {sb_q[0], link.clock_pin_b};
      sr_q     <= {sr_q[0], supply_at_level_in};
      a_q      <= sa_q[1];
      b_q      <= sb_q[1];
      a_prev_q <= a_q;
      b_prev_q <= b_q;
      cmd_prev_q <= link.cmd_trigger;
    end
  end
  wire a_fall   = a_prev_q & ~a_q;
  wire b_fall   = b_prev_q & ~b_q;
  wire cmd_rise = link.cmd_trigger & ~cmd_prev_q;
  wire level_ok = sr_q[1];

  // ****************************************
  // burst sequencer
  // ****************************************
  ubc_state_e           st_q;
  logic [PULSE_W-1:0]   cnt_q;
  logic [BLANK_W-1:0]   blank_q;
  logic [1:0]           ovl_q;
  logic                 burst_end;
  wire count_done = (burst_pulse_in != PULSE_RST) &&
                    (cnt_q == burst_pulse_in - 8'h01);
  wire ovl_hit    = (io_mode_in == MODE_TWO_PIN) && (ovl_q == 2'(OVERLAP_CYC));
  always_comb begin
    burst_end = 1'b0;
    if (st_q == UBC_BURST) begin
      case (io_mode_in)
        MODE_CMD:      burst_end = !link.cmd_trigger || (b_fall && count_done);
        MODE_PIN_A:    burst_end = a_q || (b_fall && count_done);
        MODE_TWO_PIN:  burst_end = ovl_hit;
        MODE_CLK_ONLY: burst_end = b_fall && (cnt_q == burst_pulse_in - 8'h01);
        default:       burst_end = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ovl_q <= OVERLAP_RST;
    end else if (clk_en_in) begin
      if (st_q == UBC_BURST && a_q && b_q && ovl_q != 2'(OVERLAP_CYC))
        ovl_q <= ovl_q + 2'h1;
      else if (!(a_q && b_q) || st_q != UBC_BURST)
        ovl_q <= OVERLAP_RST;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q    <= UBC_IDLE;
      cnt_q   <= PULSE_RST;
      blank_q <= BLANK_RST;
    end else if (clk_en_in) begin
      case (st_q)
        UBC_IDLE: begin
          cnt_q <= PULSE_RST;
          case (io_mode_in)
            MODE_CMD:      if (cmd_rise) st_q <= UBC_ARMED;
            MODE_PIN_A:    if (a_fall) st_q <= UBC_ARMED;
            MODE_TWO_PIN:  if (a_fall || b_fall) st_q <= UBC_ARMED;
            MODE_CLK_ONLY: if (b_fall) st_q <= UBC_BURST;
            default:       st_q <= UBC_IDLE;
          endcase
        end
        UBC_ARMED: begin
          if ((io_mode_in == MODE_CMD && !link.cmd_trigger) ||
              (io_mode_in == MODE_PIN_A && a_q))
            st_q <= UBC_IDLE;
          else if (io_mode_in == MODE_TWO_PIN ? a_fall : b_fall)
            st_q <= UBC_BURST;
        end
        UBC_BURST: begin
          if (b_fall && io_mode_in != MODE_TWO_PIN)
            cnt_q <= cnt_q + 8'h01;
          if (burst_end) begin
            cnt_q <= PULSE_RST;
            if (io_mode_in == MODE_CLK_ONLY) begin
              blank_q <= BLANK_W'(BLANK_UNIT_CYC) * BLANK_W'(drive_fault_timeout_in);
              st_q    <= UBC_BLANK;
            end else begin
              st_q <= UBC_IDLE;
            end
          end
        end
        UBC_BLANK: begin
          if (blank_q == BLANK_RST) st_q <= UBC_IDLE;
          else blank_q <= blank_q - 12'h001;
        end
        default: st_q <= UBC_IDLE;
      endcase
    end
  end

  // ****************************************
  // drive outputs
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_out_a_out  <= 1'b0;
      drive_out_b_out  <= 1'b0;
      burst_active_out <= 1'b0;
    end else if (clk_en_in) begin
      burst_active_out <= (st_q == UBC_BURST) && !burst_end;
      if (st_q == UBC_BURST && !burst_end) begin
        drive_out_a_out <= a_q;
        drive_out_b_out <= b_q;
      end else begin
        drive_out_a_out <= 1'b0;
        drive_out_b_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // drive-supply charge gating
  // ****************************************
  logic listen_off_q;
  logic keep_charge_q;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_supply_hiz_flag_out <= HIZ_RST;
      listen_off_q              <= 1'b0;
      keep_charge_q             <= 1'b0;
      charge_enable_out         <= 1'b0;
      link.supply_ready_flag    <= 1'b0;
    end else if (clk_en_in) begin
      if (hiz_clear_in) drive_supply_hiz_flag_out <= 1'b0;
      // trigger level held at start of burst decides the stop after it
      if (st_q != UBC_BURST)
        keep_charge_q <= link.supply_recharge_trigger;
      if (drive_supply_hiz_flag_out)
        listen_off_q <= 1'b0;
      else if (st_q == UBC_BURST && burst_end && listen_charge_disable_in &&
               !keep_charge_q)
        listen_off_q <= 1'b1;
      else if (link.supply_recharge_trigger)
        listen_off_q <= 1'b0;
      charge_enable_out <= !drive_supply_hiz_flag_out && !listen_off_q &&
                           !level_ok;
      link.supply_ready_flag <= !drive_supply_hiz_flag_out && level_ok;
    end
  end
  wire unused_level = ^drive_supply_level_sel_in;
endmodule

// File: hw/ubc_host.sv
// controller end: drives the pins and trigger bits from user requests
`timescale 1ns/1ps
module ubc_host (
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  ubc_link_if.host  link,
  input  wire logic pin_a_in,
  input  wire logic pin_b_in,
  input  wire logic cmd_trigger_in,
  input  wire logic recharge_in,
  output logic      supply_ready_out
);
  import ubc_pkg::*;
  // ****************************************
  // pin and bit drivers
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link.control_pin_a           <= 1'b1;
      link.clock_pin_b             <= 1'b1;
      link.cmd_trigger             <= 1'b0;
      link.supply_recharge_trigger <= 1'b0;
      supply_ready_out             <= 1'b0;
    end else if (clk_en_in) begin
      link.control_pin_a           <= pin_a_in;
      link.clock_pin_b             <= pin_b_in;
      link.cmd_trigger             <= cmd_trigger_in;
      link.supply_recharge_trigger <= recharge_in & ~cmd_trigger_in;
      supply_ready_out             <= link.supply_ready_flag;
    end
  end
endmodule

// File: tb/ubc_link_properties.sv
// concurrent checks on the burst link and the device pins
`timescale 1ns/1ps
module ubc_link_checker (
  input wire logic       ref_clk_in,
  input wire logic       reset_n_in,
  input wire logic [1:0] io_mode_in,
  input wire logic       control_pin_a,
  input wire logic       clock_pin_b,
  input wire logic       cmd_trigger,
  input wire logic       hiz_clear_in,
  input wire logic       supply_at_level_in,
  input wire logic       drive_out_b_out,
  input wire logic       charge_enable_out,
  input wire logic       drive_supply_hiz_flag_out,
  input wire logic       burst_active_out
);
  import ubc_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_hiz_off; drive_supply_hiz_flag_out |-> !charge_enable_out; endproperty
  a_hiz_off: assert property (p_hiz_off) else $error("charging while hiz set");
  property p_hiz_clr; hiz_clear_in |-> ##[1:3] !drive_supply_hiz_flag_out; endproperty
  a_hiz_clr: assert property (p_hiz_clr) else $error("hiz flag not cleared");
  property p_level; supply_at_level_in [*5] |-> !charge_enable_out; endproperty
  a_level: assert property (p_level) else $error("charging above level");
  property p_follow; (burst_active_out && $stable(clock_pin_b)) [*8] |->
    drive_out_b_out == clock_pin_b; endproperty
  a_follow: assert property (p_follow) else $error("output b not following");
  property p_cmd_end; io_mode_in == MODE_CMD && $fell(cmd_trigger) |->
    ##[1:8] !burst_active_out; endproperty
  a_cmd_end: assert property (p_cmd_end) else $error("burst outlives command");
  property p_a_end; io_mode_in == MODE_PIN_A && $rose(control_pin_a) |->
    ##[1:8] !burst_active_out; endproperty
  a_a_end: assert property (p_a_end) else $error("burst outlives pin a");
  property p_overlap; (io_mode_in == MODE_TWO_PIN && control_pin_a && clock_pin_b) [*4] |->
    ##[0:6] !burst_active_out; endproperty
  a_overlap: assert property (p_overlap) else $error("overlap kept burst");
  property p_blank; io_mode_in == MODE_CLK_ONLY && $fell(burst_active_out) |->
    !burst_active_out [*8]; endproperty
  a_blank: assert property (p_blank) else $error("burst during blank");
  c_cmd: cover property (burst_active_out && io_mode_in == MODE_CMD);
  c_two: cover property (burst_active_out && io_mode_in == MODE_TWO_PIN);
  c_hiz: cover property ($fell(drive_supply_hiz_flag_out));
endmodule

// File: tb/ultrasonic_burst_control_tb_top.sv
// self-checking bench joining the controller and device ends
`timescale 1ns/1ps
module ultrasonic_burst_control_tb_top;
  import ubc_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       pin_a = 1'b1, pin_b = 1'b1, cmd = 1'b0, rchg = 1'b0;
  logic       listen = 1'b0, hiz_clr = 1'b0, at_level = 1'b0, en = 1'b1;
  logic [1:0] mode = MODE_CMD;
  logic [7:0] pulses = 8'h03;
  logic [2:0] tmo = 3'h1;
  logic       out_a, out_b, charge, hiz, active, ready;
  int         failures = 0;
  int         check_count = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  ubc_link_if ubc_link_if_i ();
  ubc_host ubc_host_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .clk_en_in(en),
    .link(ubc_link_if_i), .pin_a_in(pin_a), .pin_b_in(pin_b), .cmd_trigger_in(cmd),
    .recharge_in(rchg), .supply_ready_out(ready));
  ubc_device ubc_device_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .clk_en_in(en),
    .link(ubc_link_if_i), .io_mode_in(mode), .burst_pulse_in(pulses),
    .drive_fault_timeout_in(tmo), .drive_supply_level_sel_in(4'h8),
    .listen_charge_disable_in(listen), .hiz_clear_in(hiz_clr), .supply_at_level_in(at_level),
    .drive_out_a_out(out_a), .drive_out_b_out(out_b), .charge_enable_out(charge),
    .drive_supply_hiz_flag_out(hiz), .burst_active_out(active));
  ubc_link_checker ubc_link_checker_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .io_mode_in(mode), .control_pin_a(ubc_link_if_i.control_pin_a),
    .clock_pin_b(ubc_link_if_i.clock_pin_b), .cmd_trigger(ubc_link_if_i.cmd_trigger),
    .hiz_clear_in(hiz_clr), .supply_at_level_in(at_level), .drive_out_b_out(out_b),
    .charge_enable_out(charge), .drive_supply_hiz_flag_out(hiz), .burst_active_out(active));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic pins(input logic a, input logic b);
    @(negedge ref_clk_in);
    pin_a = a;
    pin_b = b;
    repeat (12) @(negedge ref_clk_in);
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_supply();
    chk(hiz, 1'b1);
    rchg = 1'b1;
    pins(1'b1, 1'b1);
    chk(charge, 1'b0);
    rchg = 1'b0;
    hiz_clr = 1'b1;
    @(negedge ref_clk_in) hiz_clr = 1'b0;
    pins(1'b1, 1'b1);
    chk(hiz, 1'b0);
    chk(charge, 1'b1);
    at_level = 1'b1;
    pins(1'b1, 1'b1);
    chk(charge, 1'b0);
    chk(ready, 1'b1);
    at_level = 1'b0;
    $display("test supply done");
  endtask
  task automatic t_mode0();
    chk(ubc_link_if_i.clock_pin_b, 1'b1);
    listen = 1'b1;
    cmd = 1'b1;
    pins(1'b1, 1'b1);
    chk(active, 1'b0);
    pins(1'b1, 1'b0);
    chk(active, 1'b1);
    chk(out_a, 1'b1);
    repeat (2) begin
      pins(1'b1, 1'b1);
      pins(1'b1, 1'b0);
    end
    chk(active, 1'b1);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b0);
    chk(charge, 1'b0);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b0);
    cmd = 1'b0;
    rchg = 1'b1;
    pins(1'b1, 1'b1);
    chk(charge, 1'b1);
    rchg = 1'b0;
    cmd = 1'b1;
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b1);
    cmd = 1'b0;
    pins(1'b1, 1'b0);
    chk(active, 1'b0);
    $display("test mode 0 done");
  endtask
  task automatic t_mode1();
    mode = MODE_PIN_A;
    pulses = 8'h00;
    rchg = 1'b1;
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b1);
    chk(active, 1'b0);
    pins(1'b0, 1'b0);
    chk(active, 1'b1);
    rchg = 1'b0;
    repeat (4) begin
      pins(1'b0, 1'b1);
      pins(1'b0, 1'b0);
    end
    chk(active, 1'b1);
    pins(1'b0, 1'b1);
    chk(out_b, 1'b1);
    chk(out_a, 1'b0);
    pins(1'b1, 1'b0);
    chk(active, 1'b0);
    chk(charge, 1'b1);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b0);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    chk(active, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b0);
    chk(charge, 1'b0);
    $display("test mode 1 done");
  endtask
  task automatic t_mode2();
    mode = MODE_TWO_PIN;
    pulses = 8'h01;
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b0);
    pins(1'b0, 1'b0);
    chk(active, 1'b1);
    repeat (3) begin
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
    end
    chk(active, 1'b1);
    pins(1'b1, 1'b1);
    chk(active, 1'b0);
    pins(1'b0, 1'b1);
    chk(active, 1'b0);
    $display("test mode 2 done");
  endtask
  task automatic t_mode3();
    mode = MODE_CLK_ONLY;
    pulses = 8'h02;
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b1);
    repeat (2) begin
      pins(1'b1, 1'b1);
      pins(1'b1, 1'b0);
    end
    chk(active, 1'b0);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b0);
    repeat (100) @(negedge ref_clk_in);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b1);
    en = 1'b0;
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b1);
    en = 1'b1;
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b1);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk(active, 1'b0);
    $display("test mode 3 done");
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    t_supply();
    t_mode0();
    t_mode1();
    t_mode2();
    t_mode3();
    final_report();
  end
  initial begin
    #60us;
    failures++;
    final_report();
  end
endmodule
